// [rtl/adc_compute_defines.vh]
// Purpose: constants for the post-conversion compute unit
// Assumes: one 250 MHz clock, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
// Behaviour
// - Five modes, three-bit code 0..4
// - Basic: accumulator and count untouched, test always
// - Basic: done flag after all conversions
// - Accumulate: add sample, bump count
// - Count saturates at 0xFF
// - Filtered result is accumulator shifted right, unshifted accumulator in Filter mode
// - Accumulate: done each sample, test each sample
// - Average: test only when count reaches target
// - Average: restart clears when count at target
// - Burst: trigger clears, repeat until target
// - Filter: acc = sample + acc - acc>>shift
// - Filter: test every trigger after target reached
// - Sample is result, or second minus first
// - Clear command zeroes state, self clears
// - Clear takes five oscillator ticks with oscillator selected, else one clock
// - Overflow when sum exceeds 262143
// - Shift field sets right shift amount
// - Software start or external trigger steps
// - Burst retriggers without continuous sampling
// - Met threshold condition sets threshold flag
// - Overflow forces threshold flag at test
`ifndef ADC_COMPUTE_DEFINES_VH
`define ADC_COMPUTE_DEFINES_VH
`define MODE_BASIC        3'h0
`define MODE_ACCUM        3'h1
`define MODE_AVERAGE      3'h2
`define MODE_BURST        3'h3
`define MODE_LOWPASS      3'h4
`define ACC_W             18
`define ACC_MAX           18'h3FFFF
`define CNT_MAX           8'hFF
`define CLEAR_CYCLES      3'h5
`define REG_CONTROL       6'h00
`define REG_STATUS        6'h04
`define REG_ACCUM         6'h08
`define REG_FILTERED      6'h0C
`define REG_COUNT         6'h10
`define REG_REPEAT        6'h14
`define REG_RESULT        6'h18
`define REG_PREV          6'h1C
`define CTL_MODE_LSB      0
`define CTL_SHIFT_LSB     4
`define CTL_DSEN_BIT      8
`define CTL_CONTINUOUS_SAMPLING_BIT      9
`define CTL_OSC_BIT       10
`define CTL_START_BIT     16
`define CTL_CLEAR_BIT     17
`define ST_DONE_BIT       0
`define ST_THRESH_BIT     1
`define ST_OVF_BIT        2
`define ST_FIRST_BIT      3
`define ST_BUSY_BIT       4
`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2
`endif

// [rtl/adc_post_compute.v]
// Purpose: post-conversion computation with AXI4-Lite registers
// Assumes: core hands results as one-cycle strobes in the clk domain
// Notes: threshold comparison is outside; this unit says when to test
`include "adc_compute_defines.vh"
module adc_post_compute #(
    parameter ACC_W  = `ACC_W,
    parameter RES_W  = 12,
    parameter CNT_W  = 8
) (
    input  wire             clk,
    input  wire             sys_rst,
    // AXI4-Lite slave
    input  wire [5:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output reg              s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output reg              s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    input  wire [5:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output reg              s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    // Converter core side
    input  wire             ext_trigger,
    input  wire             osc_tick,
    input  wire             result_valid,
    input  wire [RES_W-1:0] conversion_result,
    input  wire             threshold_met,
    output reg              conv_start,
    output reg              threshold_test,
    output reg              conversion_done_flag,
    output reg              threshold_hit_flag
);
    // One-hot sequencer states
    localparam ST_IDLE  = 4'b0001; // Waiting for a trigger
    localparam ST_CONV  = 4'b0010; // Conversion requested, wait result
    localparam ST_CALC  = 4'b0100; // Apply sample to accumulator
    localparam ST_NEXT  = 4'b1000; // Decide on retrigger

    // Software visible control
    reg  [2:0]       compute_mode_sel;      // Mode code
    reg  [2:0]       accum_shift_sel;       // Shift amount
    reg              double_sample_enable;  // Two conversions per trigger
    reg              continuous_sampling;   // Auto retrigger
    reg              osc_clock_sel;         // Core runs on dedicated_internal_osc
    reg              start_bit;             // Conversion in progress
    reg              accum_clear_cmd;       // Clear pending
    reg  [2:0]       clear_cnt;             // Oscillator ticks seen while clearing
    reg  [CNT_W-1:0] repeat_target;         // Repeat target
    // Compute state
    reg  [ACC_W-1:0] accumulator_value;     // Accumulator
    reg  [ACC_W-1:0] filtered_value;        // Shifted result
    reg  [CNT_W-1:0] sample_count;          // Saturating count
    reg              accum_overflow_flag;   // Sticky overflow
    reg              first_seen;            // First of double pair done
    reg  [RES_W-1:0] prev_result;           // First sample of pair
    reg  [RES_W-1:0] last_result;           // Latest result
    reg  [3:0]       state;                 // Sequencer
    reg              burst_pending;         // Fresh burst trigger

    wire [ACC_W-1:0] acc_shifted;           // Accumulator >> shift
    reg  [ACC_W:0]   next_sum;              // One extra bit for overflow
    reg  [ACC_W-1:0] sample_ext;            // Sample at accumulator width
    reg  [RES_W:0]   diff;                  // Signed difference

    sample_shifter #(.WIDTH(ACC_W)) u_shift (
        .din    (accumulator_value),
        .amount (accum_shift_sel),
        .dout   (acc_shifted)
    );

    // AXI write path: take address and data together
    wire wr_fire   = s_axi_awvalid & s_axi_wvalid & s_axi_awready & s_axi_wready;
    wire wr_ctl    = wr_fire & (s_axi_awaddr == `REG_CONTROL);
    wire wr_status = wr_fire & (s_axi_awaddr == `REG_STATUS) & s_axi_wstrb[0];
    wire wr_known  = (s_axi_awaddr == `REG_CONTROL) | (s_axi_awaddr == `REG_STATUS) |
                     (s_axi_awaddr == `REG_REPEAT);

    // Trigger from software start edge or external event
    wire sw_go    = s_axi_wvalid & s_axi_awvalid & s_axi_awready & s_axi_wready
                    & (s_axi_awaddr == `REG_CONTROL) & s_axi_wstrb[2]
                    & s_axi_wdata[`CTL_START_BIT];
    wire trig     = (sw_go | ext_trigger) & (state == ST_IDLE) & ~accum_clear_cmd;
    wire is_accum = (compute_mode_sel != `MODE_BASIC);
    wire pair_end = ~double_sample_enable | first_seen;
    wire at_rpt   = (sample_count >= repeat_target);

    // Sample from the latched result: core lines move once valid drops
    always @* begin
        diff = {1'b0, last_result} - {1'b0, prev_result};
        if (double_sample_enable)
            sample_ext = {{(ACC_W-RES_W-1){diff[RES_W]}}, diff};
        else
            sample_ext = {{(ACC_W-RES_W){1'b0}}, last_result};
    end

    // Next accumulator value per mode
    always @* begin
        next_sum = {1'b0, accumulator_value};
        case (compute_mode_sel)
            `MODE_ACCUM, `MODE_AVERAGE, `MODE_BURST:
                next_sum = {1'b0, accumulator_value} + {1'b0, sample_ext};
            `MODE_LOWPASS:
                next_sum = {1'b0, accumulator_value} + {1'b0, sample_ext}
                           - {1'b0, acc_shifted};
            default:
                next_sum = {1'b0, accumulator_value};
        endcase
    end

    // Signed difference may wrap below zero; only a carry past the top counts
    wire sum_ovf = next_sum[ACC_W] & ~(double_sample_enable & diff[RES_W]);

    // Test decision for the current pair
    reg  do_test;
    reg  [CNT_W-1:0] next_count;
    always @* begin
        next_count = (sample_count == `CNT_MAX) ? sample_count : sample_count + 1'b1;
        case (compute_mode_sel)
            `MODE_BASIC:   do_test = 1'b1;
            `MODE_ACCUM:   do_test = 1'b1;
            `MODE_AVERAGE: do_test = (next_count >= repeat_target);
            `MODE_BURST:   do_test = (next_count >= repeat_target);
            `MODE_LOWPASS: do_test = (next_count >= repeat_target);
            default:       do_test = 1'b0;
        endcase
    end

    // Sequencer and compute datapath
    always @(posedge clk) begin
        if (sys_rst) begin
            state                <= ST_IDLE;
            accumulator_value    <= {ACC_W{1'b0}};
            filtered_value       <= {ACC_W{1'b0}};
            sample_count         <= {CNT_W{1'b0}};
            accum_overflow_flag  <= 1'b0;
            first_seen           <= 1'b0;
            prev_result          <= {RES_W{1'b0}};
            last_result          <= {RES_W{1'b0}};
            conv_start           <= 1'b0;
            threshold_test       <= 1'b0;
            conversion_done_flag <= 1'b0;
            threshold_hit_flag   <= 1'b0;
            start_bit            <= 1'b0;
            burst_pending        <= 1'b0;
            clear_cnt            <= 3'h0;
        end else begin
            conv_start     <= 1'b0;
            threshold_test <= 1'b0;
            // Software clears flags by writing one; hardware set below wins
            if (wr_status) begin
                if (s_axi_wdata[`ST_DONE_BIT])   conversion_done_flag <= 1'b0;
                if (s_axi_wdata[`ST_THRESH_BIT]) threshold_hit_flag   <= 1'b0;
            end
            // Clear command: zero state, wait for five ticks on oscillator
            if (accum_clear_cmd) begin
                accumulator_value   <= {ACC_W{1'b0}};
                sample_count        <= {CNT_W{1'b0}};
                accum_overflow_flag <= 1'b0;
                if (osc_clock_sel & osc_tick)
                    clear_cnt <= clear_cnt + 3'h1;
            end else begin
                clear_cnt <= 3'h0;
            end
            case (state)
                ST_IDLE: begin
                    if (trig) begin
                        start_bit  <= 1'b1;
                        conv_start <= 1'b1;
                        state      <= ST_CONV;
                        // Restart of a finished average set, or any burst trigger
                        if ((compute_mode_sel == `MODE_AVERAGE && at_rpt) ||
                            compute_mode_sel == `MODE_BURST) begin
                            accumulator_value <= {ACC_W{1'b0}};
                            sample_count      <= {CNT_W{1'b0}};
                        end
                        burst_pending <= (compute_mode_sel == `MODE_BURST);
                    end
                end
                ST_CONV: begin
                    if (~start_bit) begin
                        // Software abort: no flag, no compute
                        state      <= ST_IDLE;
                        first_seen <= 1'b0;
                    end else if (result_valid) begin
                        last_result <= conversion_result;
                        state       <= ST_CALC;
                    end
                end
                ST_CALC: begin
                    // Double sample: one difference per pair
                    if (is_accum & pair_end) begin
                        accumulator_value <= next_sum[ACC_W-1:0];
                        sample_count      <= next_count;
                        if (sum_ovf)
                            accum_overflow_flag <= 1'b1;
                    end
                    if (pair_end) begin
                        first_seen <= 1'b0;
                        conversion_done_flag <= 1'b1;
                        if (do_test) begin
                            threshold_test <= 1'b1;
                            if (threshold_met | accum_overflow_flag | sum_ovf)
                                threshold_hit_flag <= 1'b1;
                        end
                    end else begin
                        first_seen  <= 1'b1;
                        prev_result <= last_result;
                    end
                    state <= ST_NEXT;
                end
                ST_NEXT: begin
                    filtered_value <= (compute_mode_sel == `MODE_LOWPASS)
                                      ? accumulator_value : acc_shifted;
                    burst_pending  <= 1'b0;
                    if (~start_bit) begin
                        state      <= ST_IDLE;
                        first_seen <= 1'b0;
                    end else if (first_seen) begin
                        conv_start <= 1'b1; // Second conversion of the pair
                        state      <= ST_CONV;
                    end else if (compute_mode_sel == `MODE_BURST && !at_rpt) begin
                        conv_start <= 1'b1;
                        state      <= ST_CONV;
                    end else if (continuous_sampling) begin
                        if (compute_mode_sel == `MODE_AVERAGE && at_rpt) begin
                            accumulator_value <= {ACC_W{1'b0}};
                            sample_count      <= {CNT_W{1'b0}};
                        end
                        conv_start <= 1'b1;
                        state      <= ST_CONV;
                    end else begin
                        start_bit <= 1'b0;
                        state     <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Software write to start bit may abort a running cycle
            if (wr_ctl & s_axi_wstrb[2] & ~s_axi_wdata[`CTL_START_BIT] & (state != ST_IDLE))
                start_bit <= 1'b0;
        end
    end

    // Control registers and clear command
    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready        <= 1'b0;
            s_axi_wready         <= 1'b0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= `AXI_OKAY;
            compute_mode_sel     <= `MODE_BASIC;
            accum_shift_sel      <= 3'h0;
            double_sample_enable <= 1'b0;
            continuous_sampling  <= 1'b0;
            osc_clock_sel        <= 1'b0;
            accum_clear_cmd      <= 1'b0;
            repeat_target        <= {CNT_W{1'b0}};
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Clear ends after one cycle on the system clock, five ticks on oscillator
            if (accum_clear_cmd &&
                (~osc_clock_sel || clear_cnt == `CLEAR_CYCLES - 3'h1 && osc_tick))
                accum_clear_cmd <= 1'b0;
            if (wr_ctl) begin
                if (s_axi_wstrb[0]) begin
                    compute_mode_sel <= (s_axi_wdata[`CTL_MODE_LSB+2:`CTL_MODE_LSB] > `MODE_LOWPASS)
                                        ? `MODE_BASIC : s_axi_wdata[`CTL_MODE_LSB+2:`CTL_MODE_LSB];
                    accum_shift_sel  <= s_axi_wdata[`CTL_SHIFT_LSB+2:`CTL_SHIFT_LSB];
                end
                if (s_axi_wstrb[1]) begin
                    double_sample_enable <= s_axi_wdata[`CTL_DSEN_BIT];
                    continuous_sampling  <= s_axi_wdata[`CTL_CONTINUOUS_SAMPLING_BIT];
                    osc_clock_sel        <= s_axi_wdata[`CTL_OSC_BIT];
                end
                if (s_axi_wstrb[2] & s_axi_wdata[`CTL_CLEAR_BIT])
                    accum_clear_cmd <= 1'b1;
            end
            if (wr_fire & (s_axi_awaddr == `REG_REPEAT) & s_axi_wstrb[0])
                repeat_target <= s_axi_wdata[CNT_W-1:0];
        end
    end

    // Read mux
    reg [31:0] rd_word;
    reg        rd_known;
    always @* begin
        rd_word  = 32'h0;
        rd_known = 1'b1;
        case (s_axi_araddr)
            `REG_CONTROL:  rd_word = {14'h0, accum_clear_cmd, start_bit, 5'h0, osc_clock_sel,
                                      continuous_sampling, double_sample_enable, 1'b0,
                                      accum_shift_sel, 1'b0, compute_mode_sel};
            `REG_STATUS:   rd_word = {27'h0, (state != ST_IDLE), first_seen, accum_overflow_flag,
                                      threshold_hit_flag, conversion_done_flag};
            `REG_ACCUM:    rd_word = {{(32-ACC_W){1'b0}}, accumulator_value};
            `REG_FILTERED: rd_word = {{(32-ACC_W){1'b0}}, filtered_value};
            `REG_COUNT:    rd_word = {{(32-CNT_W){1'b0}}, sample_count};
            `REG_REPEAT:   rd_word = {{(32-CNT_W){1'b0}}, repeat_target};
            `REG_RESULT:   rd_word = {{(32-RES_W){1'b0}}, last_result};
            `REG_PREV:     rd_word = {{(32-RES_W){1'b0}}, prev_result};
            default:       rd_known = 1'b0;
        endcase
    end

    // AXI read path: one read at a time
    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `AXI_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_known ? `AXI_OKAY : `AXI_SLVERR;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // adc_post_compute

// [rtl/sample_shifter.v]
// Purpose: logical right shift of the accumulator by the shift field
// Assumes: shift field three bits wide
// Notes: shared by the filtered output and the low-pass update
module sample_shifter #(
    parameter WIDTH = 18
) (
    input  wire [WIDTH-1:0] din,
    input  wire [2:0]       amount,
    output wire [WIDTH-1:0] dout
);
    // Zero fill: accumulator is treated as unsigned magnitude
    assign dout = din >> amount;
endmodule // sample_shifter

// [testbench/adc_post_compute_properties.sv]
// Purpose: port-level checks of the post-conversion compute unit
// Assumes: one clock, synchronous active-high reset
// Notes: test and flag timing follow the hand-over latencies
module adc_post_compute_properties (
    input wire        clk,
    input wire        sys_rst,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        result_valid,
    input wire        conv_start,
    input wire        threshold_test,
    input wire        conversion_done_flag,
    input wire        threshold_hit_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_write_resp: assert property (s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_resp: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_test_cause: assert property (threshold_test |-> $past(result_valid, 2))
        else $error("test without a result");
    a_test_pulse: assert property (threshold_test |=> !threshold_test)
        else $error("test pulse too long");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_hit_cause: assert property ($rose(threshold_hit_flag) |-> threshold_test)
        else $error("threshold flag without a test");
    a_hit_sticky: assert property (threshold_hit_flag && !s_axi_wready |=> threshold_hit_flag)
        else $error("threshold flag lost");
    a_done_cause: assert property ($rose(conversion_done_flag) |-> $past(result_valid, 2))
        else $error("done flag without a result");
endmodule // adc_post_compute_properties

// [testbench/conv_core_model.sv]
// Purpose: behavioural converter core answering each start request
// Assumes: latency and sample value set by the bench
// Notes: result lines toggle when not valid so stale data never passes
module conv_core_model (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        conv_start,
    input  wire [2:0]  lat,
    input  wire [11:0] smp,
    output logic       result_valid,
    output logic [11:0] conversion_result
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt; // Cycles left in the conversion
    // Count down the conversion, then present one result
    always @(posedge clk) begin
        result_valid <= 1'b0;
        conversion_result <= ~conversion_result;
        if (sys_rst) begin
            wait_cnt <= 4'h0;
            conversion_result <= 12'h000;
        end else if (conv_start) begin
            wait_cnt <= {1'b0, lat} + 4'h1;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
            // Last cycle: the sample stands for one edge
            if (wait_cnt == 4'h1) begin
                result_valid <= 1'b1;
                conversion_result <= smp;
            end
        end
    end
endmodule // conv_core_model

// [testbench/tb.sv]
// Purpose: self-checking bench for the post-conversion compute unit
// Assumes: samples advance by stp after every result
// Notes: flags polled over the register bus or read at ports, some after fixed delays
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [5:0] awa = 6'h00, ara = 6'h00;
    logic [31:0] wd = 32'h0, r, c;
    logic ext_trigger = 0, osc_tick = 0, threshold_met = 0;
    logic [11:0] smp = 12'h000, stp = 12'h000;
    logic [2:0] lat = 3'h2, sh;
    logic [1:0] tk = 2'h0, bs, rs;
    logic [17:0] ea;
    wire awready, wready, bvalid, arready, rvalid, rv, cs, tt, done_f, hit_f;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] res;
    integer err_total = 0, comparisons = 0, seed = 32'h38bd, tests = 0, t0, i;
    always #2 clk = ~clk;
    // Sample source, oscillator ticks, test pulse count
    always @(posedge clk) begin
        if (rv) smp <= smp + stp;
        tk <= tk + 2'h1;
        osc_tick <= (tk == 2'h3);
        if (tt) tests <= tests + 1;
    end
    adc_post_compute u_dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trigger(ext_trigger),
        .osc_tick(osc_tick), .result_valid(rv), .conversion_result(res), .threshold_met(threshold_met),
        .conv_start(cs), .threshold_test(tt), .conversion_done_flag(done_f), .threshold_hit_flag(hit_f));
    conv_core_model u_core (.clk(clk), .sys_rst(sys_rst), .conv_start(cs), .lat(lat), .smp(smp),
        .result_valid(rv), .conversion_result(res));
    // Filter step and series sum for expectations
    function [17:0] lpf(input [17:0] a, input [11:0] s, input [2:0] k);
        lpf = a + s - (a >> k);
    endfunction
    function [17:0] ser(input [11:0] s0, input [11:0] st, input integer n);
        logic [11:0] s;
        s = s0;
        ser = 0;
        for (int k = 0; k < n; k++) begin
            ser = ser + s;
            s = s + st;
        end
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bready <= 1;
        do @(posedge clk); while (awready !== 1'b1);
        awv <= 0; wv <= 0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bs = bresp;
        bready <= 0;
    endtask
    task rd(input [5:0] a);
        @(posedge clk);
        ara <= a; arv <= 1; rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arv <= 0;
        do @(posedge clk); while (rvalid !== 1'b1);
        r = rdata; rs = rresp;
        rready <= 0;
    endtask
    // One trigger by start bit or external pulse, then wait for idle
    task go(input [31:0] cw, input bit ext);
        lat <= $random(seed);
        if (ext) begin
            @(posedge clk) ext_trigger <= 1;
            @(posedge clk) ext_trigger <= 0;
        end else wr(6'h00, cw | 32'h10000);
        do rd(6'h04); while (r[4] !== 1'b0);
    endtask
    task clr(input [31:0] cw);
        wr(6'h00, cw | 32'h20000);
        do rd(6'h00); while (r[17] !== 1'b0);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000 err_total++;
        results;
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        // Reset values, last address unmapped
        for (i = 0; i < 9; i++) begin
            rd(i * 4);
            chk(r, 0);
            chk(rs, i == 8 ? 2 : 0);
        end
        wr(6'h24, 32'hFFFFFFFF);
        chk(bs, 2);
        // Accumulate with random samples and shift
        sh = $random(seed); smp <= $random(seed); stp <= $random(seed) & 12'h0FF;
        c = 32'h1 | (sh << 4); t0 = tests;
        wr(6'h00, c);
        ea = ser(smp, stp, 4);
        for (i = 0; i < 4; i++) go(c, i[0]);
        rd(6'h08); chk(r, ea);
        rd(6'h10); chk(r, 4);
        rd(6'h0C); chk(r, ea >> sh);
        rd(6'h04); chk(r[0], 1);
        chk(tests - t0, 4);
        clr(c);
        rd(6'h08); chk(r, 0);
        rd(6'h10); chk(r, 0);
        wr(6'h00, 32'h20400);
        rd(6'h00); chk(r[17], 1);
        repeat (30) @(posedge clk);
        rd(6'h00); chk(r[17], 0);
        // Basic mode with condition met
        t0 = tests; threshold_met <= 1;
        wr(6'h00, 0); go(0, 0);
        chk(tests - t0, 1);
        chk(hit_f, 1);
        rd(6'h08); chk(r, 0);
        threshold_met <= 0;
        wr(6'h04, 32'h3);
        rd(6'h04); chk(r[1:0], 0);
        // Basic double sample: done only after the pair
        wr(6'h00, 32'h100); wr(6'h00, 32'h10100);
        @(posedge clk iff rv);
        repeat (3) @(posedge clk);
        chk(done_f, 0);
        do rd(6'h04); while (r[4] !== 1'b0);
        chk(r[0], 1);
        // Accumulate a negative difference
        clr(32'h101); stp <= 12'hFF0; smp <= 12'h800;
        go(32'h101, 0);
        rd(6'h08); chk(r, 32'h3FFF0);
        rd(6'h04); chk(r[2], 0);
        // Average: third trigger starts a new set
        clr(2); stp <= 0; smp <= $random(seed);
        wr(6'h14, 2); t0 = tests;
        for (i = 0; i < 3; i++) go(2, 0);
        rd(6'h08); chk(r, smp);
        rd(6'h10); chk(r, 1);
        chk(tests - t0, 1);
        // Burst twice, each from a cleared sum
        clr(3); stp <= $random(seed) & 12'h0FF;
        wr(6'h14, 5); t0 = tests;
        go(3, 0);
        ea = ser(smp, stp, 5);
        go(3, 0);
        rd(6'h08); chk(r, ea);
        rd(6'h10); chk(r, 5);
        chk(tests - t0, 2);
        // Low-pass: test on every trigger after target
        clr(32'h24); wr(6'h14, 2); t0 = tests; ea = 0;
        for (i = 0; i < 4; i++) begin
            ea = lpf(ea, smp, 3'h2);
            go(32'h24, 0);
        end
        rd(6'h0C); chk(r, ea);
        chk(tests - t0, 3);
        // Long burst overflows, then count saturates
        clr(3); wr(6'h04, 32'h3); smp <= 12'hFFF; stp <= 0;
        wr(6'h14, 32'hFF);
        go(3, 0);
        rd(6'h04); chk(r[2], 1);
        chk(hit_f, 1);
        wr(6'h00, 1); // Mode set before the start edge
        go(1, 0);
        rd(6'h10); chk(r, 32'hFF);
        results;
    end
endmodule // tb
bind adc_post_compute adc_post_compute_properties u_props (.*);
